/* shared/acc_pkg.sv */
package acc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_INSEL = 8'h08;
   localparam logic [7:0] OFF_RES_LO = 8'h0c;
   localparam logic [7:0] OFF_RES_HI = 8'h10;
   localparam logic [7:0] OFF_PIN_DIS = 8'h14;
   localparam logic [7:0] OFF_POWER = 8'h18;
   localparam logic [7:0] OFF_PIN_IN = 8'h1c;
   // Control A fields
   localparam int CA_ENABLE = 7;
   localparam int CA_START = 6;
   localparam int CA_AUTO = 5;
   localparam int CA_DONE = 4;
   // Control B fields
   localparam int CB_MUX_EN = 6;
   localparam int CB_TRIG_LO = 0;
   // Input select fields
   localparam int IS_REF_LO = 6;
   localparam int IS_LEFT = 5;
   localparam int IS_CHAN_LO = 0;
   // Power register field
   localparam int PW_REDUCE = 0;
   // Reset values
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_INSEL = 8'h00;
   localparam logic [1:0] RST_PIN_DIS = 2'h0;
   localparam logic RST_POWER = 1'b0;
   // Converter clock divide and conversion lengths in converter cycles
   localparam int CCLK_DIV = 128;
   localparam logic [4:0] CONV_NORMAL = 5'd13;
   localparam logic [4:0] CONV_FIRST = 5'd25;
   // Trigger source that loops the done flag back (free running)
   localparam logic [2:0] TRIG_SELF = 3'h0;
   // Conversion states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_CONV = 3'b100
   } acc_state_t;
endpackage

/* logic/acc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module acc_sync #(
   parameter int W = 2
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;

   // Two-stage synchroniser, first stage read only by the second
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         meta_r <= '0;
         dout <= '0;
      end
      else
      begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* logic/acc_prescaler.sv */
`timescale 1ns/100ps
`default_nettype none
module acc_prescaler
   import acc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic run,
   input wire logic restart,
   output logic tick
);
   logic [6:0] count_r;

   // Divider held cleared while not running or on restart
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         count_r <= 7'h00;
         tick <= 1'b0;
      end
      else if (!run || restart)
      begin
         count_r <= 7'h00;
         tick <= 1'b0;
      end
      else
      begin
         count_r <= count_r + 7'h01;
         tick <= (count_r == 7'(CCLK_DIV - 1));
      end
   end
endmodule
`default_nettype wire

/* logic/acc_conversion_control.sv */
// How it works
// - Mux on and converter off: low three channel bits pick comparator input.
// - Otherwise the dedicated negative pin feeds the comparator.
// - Pin disable bits cut the buffer; pin reads then show zero.
// - Upper bits of the pin disable register read zero.
// - Each conversion gives a 10-bit code from the analog core.
// - Reference and channel reach the converter only once enabled.
// - Result right-justified by default, left-justified with left adjust.
// - Reading the low byte locks both result bytes against updates.
// - Reading the high byte releases the lock.
// - Done flag still sets when a locked result is discarded.
// - Writing start begins a conversion; bit clears when done.
// - Channel change mid-conversion waits until that conversion ends.
// - Auto-trigger rising edge resets the prescaler and starts converting.
// - Edges during conversion ignored; a held-high trigger never restarts.
// - Trigger flags set regardless; software clears them for new events.
// - Self trigger runs free; software starts the first conversion.
// - Start works under auto-trigger; start reads one during any conversion.
// - Power reduction bit keeps the converter unusable.
// - Channel field picks analog pins, ground or bandgap for the core.
// - Normal conversion 13 converter cycles, first after enable 25.
// - On completion write result, set flag, clear start in single mode.
// - Prescaler held in reset while the enable bit is low.
// - Comparator mux enable is bit 6 of control B, reset zero.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module acc_conversion_control
   import acc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:1] triggerIn,
   input wire logic [9:0] anaResult,
   input wire logic [1:0] cmpPinIn,
   output logic anaEnable,
   output logic anaStart,
   output logic [3:0] anaChannel,
   output logic [1:0] anaReference,
   output logic cmpNegUseMux,
   output logic [2:0] cmpNegChannel,
   output logic [1:0] cmpBufferOn
);
   import acc_pkg::*;

   logic convEnable_r, startBit_r, autoTrig_r, doneFlag_r;
   logic cmpMuxEnable_r;
   logic [2:0] trigSelect_r;
   logic [1:0] refSelect_r;
   logic leftAdjust_r;
   logic [3:0] chanSelect_r;
   logic [1:0] pinDisable_r;
   logic powerReduce_r;
   logic [9:0] result_r;
   logic lock_r;
   logic firstConv_r;
   logic [4:0] tickCount_r;
   logic trigSample_r, trigPrev_r;
   acc_state_t state_r;
   logic [9:0] resultSync;
   logic [1:0] pinSync;
   logic cclkTick;
   logic setupPhase, accessWr, accessRd;
   logic enEff, freeRun, trigEdge, startReq, autoStart, convEnd;
   logic [4:0] convLen;
   logic [7:0] pinView;
   logic [7:0] readMux;
   logic mapped;

   // Analog result and comparator pins come from outside the clock domain
   acc_sync #(.W(10)) resultSyncInst (
      .clock(clock),
      .reset(reset),
      .din(anaResult),
      .dout(resultSync)
   );

   acc_sync #(.W(2)) pinSyncInst (
      .clock(clock),
      .reset(reset),
      .din(cmpPinIn),
      .dout(pinSync)
   );

   // Converter clock enable, reset by trigger edges
   acc_prescaler prescInst (
      .clock(clock),
      .reset(reset),
      .run(enEff),
      .restart(autoStart),
      .tick(cclkTick)
   );

   // Byte view of the result for either justification
   function automatic logic [7:0] resultByte(
      input logic [9:0] res,
      input logic left,
      input logic high
   );
      logic [7:0] b;
      if (left)
         b = high ? res[9:2] : {res[1:0], 6'h00};
      else
         b = high ? {6'h00, res[9:8]} : res[7:0];
      return b;
   endfunction

   // Bus phase decode
   assign setupPhase = psel && !penable;
   assign accessWr = psel && penable && pready && pwrite;
   assign accessRd = psel && penable && pready && !pwrite;

   // Converter usable only when enabled and powered
   assign enEff = convEnable_r && !powerReduce_r;
   assign freeRun = autoTrig_r && (trigSelect_r == TRIG_SELF);
   assign trigEdge = trigSample_r && !trigPrev_r;
   assign startReq = accessWr && (paddr == OFF_CTRL_A)
      && pwdata[CA_START] && pwdata[CA_ENABLE] && !powerReduce_r;
   assign autoStart = autoTrig_r && enEff && trigEdge
      && (state_r == ST_IDLE);
   assign convLen = firstConv_r ? CONV_FIRST : CONV_NORMAL;
   assign convEnd = (state_r == ST_CONV) && cclkTick
      && (tickCount_r == convLen - 5'd1);
   assign pinView = {6'h00, pinSync & ~pinDisable_r};

   // Read data selection
   always_comb
   begin
      mapped = 1'b1;
      case (paddr)
         OFF_CTRL_A: readMux = {convEnable_r, startBit_r, autoTrig_r,
            doneFlag_r, 4'h0};
         OFF_CTRL_B: readMux = {1'b0, cmpMuxEnable_r, 3'h0, trigSelect_r};
         OFF_INSEL: readMux = {refSelect_r, leftAdjust_r, 1'b0,
            chanSelect_r};
         OFF_RES_LO: readMux = resultByte(result_r, leftAdjust_r, 1'b0);
         OFF_RES_HI: readMux = resultByte(result_r, leftAdjust_r, 1'b1);
         OFF_PIN_DIS: readMux = {6'h00, pinDisable_r};
         OFF_POWER: readMux = {7'h00, powerReduce_r};
         OFF_PIN_IN: readMux = pinView;
         default:
         begin
            readMux = 8'h00;
            mapped = 1'b0;
         end
      endcase
   end

   // Bus answer one cycle after setup
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setupPhase;
         if (setupPhase)
         begin
            prdata <= {24'h000000, readMux};
            pslverr <= !mapped;
         end
      end
   end

   // Software written configuration
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         convEnable_r <= RST_CTRL_A[CA_ENABLE];
         autoTrig_r <= RST_CTRL_A[CA_AUTO];
         cmpMuxEnable_r <= RST_CTRL_B[CB_MUX_EN];
         trigSelect_r <= RST_CTRL_B[CB_TRIG_LO +: 3];
         refSelect_r <= RST_INSEL[IS_REF_LO +: 2];
         leftAdjust_r <= RST_INSEL[IS_LEFT];
         chanSelect_r <= RST_INSEL[IS_CHAN_LO +: 4];
         pinDisable_r <= RST_PIN_DIS;
         powerReduce_r <= RST_POWER;
      end
      else if (accessWr)
      begin
         case (paddr)
            OFF_CTRL_A:
            begin
               convEnable_r <= pwdata[CA_ENABLE];
               autoTrig_r <= pwdata[CA_AUTO];
            end
            OFF_CTRL_B:
            begin
               cmpMuxEnable_r <= pwdata[CB_MUX_EN];
               trigSelect_r <= pwdata[CB_TRIG_LO +: 3];
            end
            OFF_INSEL:
            begin
               refSelect_r <= pwdata[IS_REF_LO +: 2];
               leftAdjust_r <= pwdata[IS_LEFT];
               chanSelect_r <= pwdata[IS_CHAN_LO +: 4];
            end
            OFF_PIN_DIS: pinDisable_r <= pwdata[1:0];
            OFF_POWER: powerReduce_r <= pwdata[PW_REDUCE];
            default:
            begin
            end
         endcase
      end
   end

   // Selected trigger sampled; source zero is the own done flag
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         trigSample_r <= 1'b0;
         trigPrev_r <= 1'b0;
      end
      else
      begin
         trigSample_r <= (trigSelect_r == TRIG_SELF) ? doneFlag_r
            : triggerIn[trigSelect_r];
         trigPrev_r <= trigSample_r;
      end
   end

   // Conversion sequencer
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         tickCount_r <= 5'd0;
         anaStart <= 1'b0;
      end
      else if (!enEff && !startReq) // Start may ride on the enabling write
      begin
         state_r <= ST_IDLE;
         tickCount_r <= 5'd0;
         anaStart <= 1'b0;
      end
      else
      begin
         anaStart <= 1'b0;
         case (state_r)
            ST_IDLE:
               if (startReq)
                  state_r <= ST_WAIT;
               else if (autoStart)
               begin
                  state_r <= ST_CONV;
                  tickCount_r <= 5'd0;
                  anaStart <= 1'b1;
               end
            ST_WAIT:
               if (cclkTick)
               begin
                  state_r <= ST_CONV;
                  tickCount_r <= 5'd0;
                  anaStart <= 1'b1;
               end
            ST_CONV:
               if (convEnd)
               begin
                  tickCount_r <= 5'd0;
                  if (freeRun)
                     anaStart <= 1'b1;
                  else
                     state_r <= ST_IDLE;
               end
               else if (cclkTick)
                  tickCount_r <= tickCount_r + 5'd1;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // First conversion after enable takes the long count
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         firstConv_r <= 1'b1;
      else if (!enEff)
         firstConv_r <= 1'b1;
      else if (convEnd)
         firstConv_r <= 1'b0;
   end

   // Start bit: high while busy, cleared at end in single mode
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         startBit_r <= RST_CTRL_A[CA_START];
      else if ((startReq && state_r == ST_IDLE) || autoStart)
         startBit_r <= 1'b1;
      else if (!enEff)
         startBit_r <= 1'b0;
      else if (convEnd && !freeRun)
         startBit_r <= 1'b0;
   end

   // Done flag: set wins over write-one-to-clear
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         doneFlag_r <= RST_CTRL_A[CA_DONE];
      else if (convEnd)
         doneFlag_r <= 1'b1;
      else if (accessWr && (paddr == OFF_CTRL_A) && pwdata[CA_DONE])
         doneFlag_r <= 1'b0;
   end

   // Result capture unless locked by a low byte read
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         result_r <= 10'h000;
      else if (convEnd && !lock_r)
         result_r <= resultSync;
   end

   // Lock between low and high byte reads
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         lock_r <= 1'b0;
      else if (accessRd && (paddr == OFF_RES_HI))
         lock_r <= 1'b0;
      else if (accessRd && (paddr == OFF_RES_LO))
         lock_r <= 1'b1;
   end

   // Channel and reference follow software while enabled, except during a conversion
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         anaChannel <= RST_INSEL[IS_CHAN_LO +: 4];
         anaReference <= RST_INSEL[IS_REF_LO +: 2];
         anaEnable <= 1'b0;
      end
      else
      begin
         anaEnable <= enEff;
         if (enEff && (state_r != ST_CONV || convEnd)) // Free run picks up
         begin
            anaChannel <= chanSelect_r;
            anaReference <= refSelect_r;
         end
      end
   end

   // Comparator negative input select and pin buffers
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cmpNegUseMux <= 1'b0;
         cmpNegChannel <= 3'h0;
         cmpBufferOn <= 2'h3;
      end
      else
      begin
         cmpNegUseMux <= cmpMuxEnable_r && !convEnable_r;
         cmpNegChannel <= chanSelect_r[2:0];
         cmpBufferOn <= ~pinDisable_r;
      end
   end

   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   logic [4:0] chkTicks_r;
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         chkTicks_r <= 5'd0;
      else if (state_r != ST_CONV || convEnd)
         chkTicks_r <= 5'd0;
      else if (cclkTick)
         chkTicks_r <= chkTicks_r + 5'd1;
   end

   property p_mux_sel;
      cmpMuxEnable_r && !convEnable_r |=>
         cmpNegUseMux && cmpNegChannel == $past(chanSelect_r[2:0]);
   endproperty
   a_mux_sel: assert property (p_mux_sel)
      else $error("comparator mux input wrong");

   property p_pin_sel;
      !cmpMuxEnable_r || convEnable_r |=> !cmpNegUseMux;
   endproperty
   a_pin_sel: assert property (p_pin_sel)
      else $error("dedicated pin not selected");

   property p_pin_zero;
      pinDisable_r[0] |-> !pinView[0];
   endproperty
   a_pin_zero: assert property (p_pin_zero)
      else $error("disabled pin reads one");

   property p_lock_hold;
      lock_r && convEnd |=> $stable(result_r);
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("locked result changed");

   property p_unlock;
      accessRd && paddr == OFF_RES_HI |=> !lock_r;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("high read left lock set");

   property p_flag_set;
      convEnd |=> doneFlag_r;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("done flag missing at end");

   property p_busy_start;
      state_r == ST_CONV |-> startBit_r;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("start bit low during conversion");

   property p_length;
      convEnd |-> chkTicks_r + 5'd1 == (firstConv_r ? 5'd25 : 5'd13);
   endproperty
   a_length: assert property (p_length)
      else $error("conversion length wrong");

   property p_presc_off;
      !enEff ##1 !enEff |-> !cclkTick;
   endproperty
   a_presc_off: assert property (p_presc_off)
      else $error("prescaler ticks while disabled");

   property p_single_end;
      convEnd && !freeRun |=> !startBit_r && state_r == ST_IDLE;
   endproperty
   a_single_end: assert property (p_single_end)
      else $error("single conversion did not finish");
endmodule
`default_nettype wire

/* tb/acc_ana_model.sv */
`timescale 1ns/100ps
`default_nettype none
module acc_ana_model (
   input wire logic clock,
   input wire logic anaEnable,
   input wire logic [3:0] anaChannel,
   output logic [9:0] anaResult
);
   logic [9:0] churn = 10'h155;
   // Churning pattern while off, so stale codes never look valid
   always @(posedge clock)
   begin
      churn <= ~churn;
   end
   // Code names the applied channel, so tests see which input was sampled
   assign anaResult = anaEnable ? {anaChannel, 6'h2b} : churn;
endmodule
`default_nettype wire

/* tb/acc_conversion_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module acc_conversion_control_bench;
   import acc_pkg::*;
   typedef struct packed {
      logic en;
      logic mux;
      logic [3:0] chan;
      logic [7:0] dis;
      logic expUse;
      logic [2:0] expCh;
      logic [1:0] expDis;
   } acc_row_t;
   localparam acc_row_t ROWS [10] = '{
      '{1'b0, 1'b1, 4'h0, 8'h00, 1'b1, 3'h0, 2'h0},
      '{1'b0, 1'b1, 4'h9, 8'hfd, 1'b1, 3'h1, 2'h1},
      '{1'b0, 1'b1, 4'h2, 8'h02, 1'b1, 3'h2, 2'h2},
      '{1'b0, 1'b1, 4'hb, 8'hff, 1'b1, 3'h3, 2'h3},
      '{1'b0, 1'b1, 4'h4, 8'h00, 1'b1, 3'h4, 2'h0},
      '{1'b0, 1'b1, 4'hd, 8'h01, 1'b1, 3'h5, 2'h1},
      '{1'b0, 1'b1, 4'h6, 8'h06, 1'b1, 3'h6, 2'h2},
      '{1'b0, 1'b1, 4'hf, 8'h03, 1'b1, 3'h7, 2'h3},
      '{1'b0, 1'b0, 4'h5, 8'h00, 1'b0, 3'h5, 2'h0},
      '{1'b1, 1'b1, 4'h5, 8'h00, 1'b0, 3'h5, 2'h0}
   };
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:1] triggerIn = 7'h00;
   logic [9:0] anaResult;
   logic [1:0] cmpPinIn = 2'h3;
   logic anaEnable;
   logic anaStart;
   logic [3:0] anaChannel;
   logic [1:0] anaReference;
   logic cmpNegUseMux;
   logic [2:0] cmpNegChannel;
   logic [1:0] cmpBufferOn;
   logic [31:0] rdat;
   logic rerr;
   int errorCnt = 0;
   int numChecks = 0;
   int cyc = 0;
   int startCnt = 0;
   int prevStart = 0;
   int gap = 0;
   int s;
   int t0;

   acc_conversion_control acc_conversion_control_inst (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .triggerIn(triggerIn),
      .anaResult(anaResult), .cmpPinIn(cmpPinIn), .anaEnable(anaEnable),
      .anaStart(anaStart), .anaChannel(anaChannel),
      .anaReference(anaReference), .cmpNegUseMux(cmpNegUseMux),
      .cmpNegChannel(cmpNegChannel), .cmpBufferOn(cmpBufferOn)
   );
   acc_ana_model acc_ana_model_inst (
      .clock(clock), .anaEnable(anaEnable), .anaChannel(anaChannel),
      .anaResult(anaResult)
   );

   // Clock at 50 ns
   always #25 clock = ~clock;

   // Cycle count, start pulses and spacing between them
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (anaStart === 1'b1)
      begin
         startCnt <= startCnt + 1;
         gap <= cyc - prevStart;
         prevStart <= cyc;
      end
   end

   task automatic conclude();
      $display("Checks %0d, errors %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      numChecks++;
      if (g !== e)
      begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic hang(input string nm);
      errorCnt++;
      $display("ERROR %s timed out", nm);
      conclude();
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         hang("pready");
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic waitStart(input int n);
      int k;
      k = 0;
      while (startCnt < n && k < 4000)
      begin
         @(posedge clock);
         k++;
      end
      if (startCnt < n)
         hang("start");
   endtask

   // Poll until the start bit drops
   task automatic waitIdle();
      int k;
      k = 0;
      do
      begin
         xfer(1'b0, OFF_CTRL_A, 32'h0);
         k++;
      end while (rdat[6] !== 1'b0 && k < 1500);
      if (k >= 1500)
         hang("idle");
   endtask

   function automatic logic [31:0] lenOk(input int v, input int lo);
      return {31'h0, v >= lo && v <= lo + 129};
   endfunction

   initial
   begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      // Reset state and unmapped access
      xfer(1'b0, OFF_CTRL_B, 32'h0);
      chk("ctrlB", 32'h0, rdat);
      chk("bufferReset", 32'h3, {30'h0, cmpBufferOn});
      xfer(1'b1, 8'h20, 32'hff);
      xfer(1'b0, 8'h20, 32'h0);
      chk("unmappedErr", 32'h1, {31'h0, rerr});
      chk("unmappedData", 32'h0, rdat);
      xfer(1'b1, OFF_INSEL, 32'h43);
      chk("chanOff", 32'h0, {28'h0, anaChannel});
      chk("refOff", 32'h0, {30'h0, anaReference});
      // Comparator routing and pin buffers, row by row
      foreach (ROWS[i])
      begin
         xfer(1'b1, OFF_CTRL_B, {25'h0, ROWS[i].mux, 6'h0});
         xfer(1'b1, OFF_INSEL, {28'h0, ROWS[i].chan});
         xfer(1'b1, OFF_CTRL_A, {24'h0, ROWS[i].en, 7'h0});
         xfer(1'b1, OFF_PIN_DIS, {24'h0, ROWS[i].dis});
         xfer(1'b0, OFF_PIN_DIS, 32'h0);
         chk("pinDisable", {30'h0, ROWS[i].expDis}, rdat);
         xfer(1'b0, OFF_PIN_IN, 32'h0);
         chk("pinInput", {30'h0, ~ROWS[i].expDis}, rdat);
         chk("bufferOn", {30'h0, ~ROWS[i].expDis}, {30'h0, cmpBufferOn});
         chk("negUseMux", {31'h0, ROWS[i].expUse},
            {31'h0, cmpNegUseMux});
         if (ROWS[i].expUse)
            chk("negChannel", {29'h0, ROWS[i].expCh},
               {29'h0, cmpNegChannel});
      end
      // Power reduction keeps the converter off
      xfer(1'b1, OFF_CTRL_A, 32'h0);
      s = startCnt;
      xfer(1'b1, OFF_POWER, 32'h1);
      xfer(1'b1, OFF_CTRL_A, 32'hc0);
      repeat (300) @(posedge clock);
      chk("enablePowerOff", 32'h0, {31'h0, anaEnable});
      chk("startsPowerOff", s, startCnt);
      xfer(1'b1, OFF_CTRL_A, 32'h0);
      xfer(1'b1, OFF_POWER, 32'h0);
      // First single conversion, channel 3, reference 1
      xfer(1'b1, OFF_INSEL, 32'h43);
      xfer(1'b1, OFF_CTRL_A, 32'hc0);
      repeat (2) @(posedge clock);
      chk("enableOn", 32'h1, {31'h0, anaEnable});
      chk("chanOn", 32'h3, {28'h0, anaChannel});
      chk("refOn", 32'h1, {30'h0, anaReference});
      xfer(1'b0, OFF_CTRL_A, 32'h0);
      chk("startBusy", 32'h1, {31'h0, rdat[6]});
      waitIdle();
      chk("doneSet", 32'h1, {31'h0, rdat[4]});
      xfer(1'b0, OFF_RES_LO, 32'h0);
      chk("resLoRight", 32'heb, rdat);
      xfer(1'b0, OFF_RES_HI, 32'h0);
      chk("resHiRight", 32'h0, rdat);
      xfer(1'b1, OFF_INSEL, 32'h63);
      xfer(1'b0, OFF_RES_LO, 32'h0);
      chk("resLoLeft", 32'hc0, rdat);
      xfer(1'b0, OFF_RES_HI, 32'h0);
      chk("resHiLeft", 32'h3a, rdat);
      // Low read locks; a conversion finishing then is lost
      xfer(1'b1, OFF_INSEL, 32'h05);
      xfer(1'b0, OFF_RES_LO, 32'h0);
      xfer(1'b1, OFF_CTRL_A, 32'hd0);
      xfer(1'b0, OFF_CTRL_A, 32'h0);
      chk("doneCleared", 32'h0, {31'h0, rdat[4]});
      waitIdle();
      chk("doneLocked", 32'h1, {31'h0, rdat[4]});
      xfer(1'b0, OFF_RES_HI, 32'h0);
      chk("resHiLocked", 32'h0, rdat);
      // Unlocked again; channel change mid-conversion waits
      s = startCnt;
      xfer(1'b1, OFF_CTRL_A, 32'hd0);
      waitStart(s + 1);
      xfer(1'b1, OFF_INSEL, 32'h06);
      chk("chanHeld", 32'h5, {28'h0, anaChannel});
      waitIdle();
      xfer(1'b0, OFF_RES_LO, 32'h0);
      chk("resLoNew", 32'h6b, rdat);
      xfer(1'b0, OFF_RES_HI, 32'h0);
      chk("resHiNew", 32'h1, rdat);
      // Auto trigger on source 3
      xfer(1'b1, OFF_CTRL_B, 32'h3);
      xfer(1'b1, OFF_CTRL_A, 32'hb0);
      s = startCnt;
      @(posedge clock);
      triggerIn[3] <= 1'b1;
      t0 = cyc;
      waitStart(s + 1);
      chk("trigDelay", 32'h1, {31'h0, prevStart - t0 <= 6});
      xfer(1'b0, OFF_CTRL_A, 32'h0);
      chk("startAuto", 32'h1, {31'h0, rdat[6]});
      triggerIn <= 7'h00;
      @(posedge clock);
      triggerIn <= 7'h0c;
      repeat (1900) @(posedge clock);
      chk("edgesIgnored", s + 1, startCnt);
      // Software drops the flag, then a fresh edge counts
      triggerIn <= 7'h00;
      @(posedge clock);
      triggerIn <= 7'h04;
      waitStart(s + 2);
      waitIdle();
      xfer(1'b1, OFF_CTRL_A, 32'he0);
      waitStart(s + 3);
      waitIdle();
      triggerIn <= 7'h00;
      // Free running from its own done flag, never cleared
      xfer(1'b1, OFF_CTRL_A, 32'h0);
      xfer(1'b1, OFF_CTRL_B, 32'h0);
      s = startCnt;
      xfer(1'b1, OFF_CTRL_A, 32'he0);
      waitStart(s + 2);
      chk("firstLen", 32'h1, lenOk(gap, 25 * CCLK_DIV));
      waitStart(s + 3);
      chk("normalLen", 32'h1, lenOk(gap, 13 * CCLK_DIV));
      xfer(1'b0, OFF_CTRL_A, 32'h0);
      chk("startFree", 32'h1, {31'h0, rdat[6]});
      xfer(1'b1, OFF_CTRL_A, 32'h0);
      s = startCnt;
      repeat (2000) @(posedge clock);
      chk("enableOff", 32'h0, {31'h0, anaEnable});
      chk("idleOff", s, startCnt);
      conclude();
   end
endmodule
`default_nettype wire
